/* testbench/dsc_link_checker.sv */
/* Timing checker for the link between the two converter ends.
   Assumes the host clock samples every link signal and that the
   host drives convert and the link clock from its own registers. */
`timescale 1ns/1ns
module dsc_link_checker
    import dsc_pkg::*;
#(
    parameter int FRAME = FRAME_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_rst,
    input wire logic convert,
    input wire logic conversion_clock_input,
    input wire logic data_a,
    input wire logic data_b
);
    logic [4:0] edge_cnt_reg;
    logic [9:0] gap_cnt_reg;
    logic started_reg;
    wire clk_in = conversion_clock_input;

    // ====================
    // Helper counters
    // Link edges since convert, saturating so overruns stay visible
    always_ff @(posedge clock) begin
        if (rst || $rose(convert)) begin
            edge_cnt_reg <= 5'h00;
        end else if ($rose(clk_in) && edge_cnt_reg != 5'h1F) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
        end
    end
    // Host cycles since convert
    always_ff @(posedge clock) begin
        if (rst || $rose(convert)) begin
            gap_cnt_reg <= 10'h000;
        end else if (gap_cnt_reg != 10'h3FF) begin
            gap_cnt_reg <= gap_cnt_reg + 10'h001;
        end
    end
    // First convert after reset has no earlier frame to judge
    always_ff @(posedge clock) begin
        if (rst) begin
            started_reg <= 1'b0;
        end else if ($rose(convert)) begin
            started_reg <= 1'b1;
        end
    end

    // ====================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_pulse_len: assert property (
        $rose(convert) |-> convert [*3] ##1 !convert)
        else $error("convert pulse length wrong");
    a_guard_quiet: assert property (
        $rose(convert) |-> !clk_in [*5])
        else $error("link clock rose inside guard");
    a_high_time: assert property (
        $rose(clk_in) |=> clk_in ##1 !clk_in)
        else $error("link clock high time wrong");
    a_low_time: assert property (
        $fell(clk_in) && edge_cnt_reg < 5'h13 |=> !clk_in ##1 clk_in)
        else $error("link clock low time wrong");
    a_edge_total: assert property (
        $rose(convert) && started_reg |-> edge_cnt_reg == 5'h13)
        else $error("conversion edge count not nineteen");
    a_clock_parked: assert property (
        edge_cnt_reg == 5'h13 |-> !$rose(clk_in))
        else $error("link clock ran after edge nineteen");
    a_convert_low: assert property (
        $rose(clk_in) && edge_cnt_reg == 5'h12 |-> !convert && !$past(convert))
        else $error("convert still high near edge nineteen");
    a_frame_gap: assert property (
        $rose(convert) && started_reg |-> gap_cnt_reg >= 10'(FRAME - 1))
        else $error("converts closer than one frame");
    a_data_steady: assert property (disable iff (rst || link_rst)
        !$rose(clk_in) |-> $stable(data_a) && $stable(data_b))
        else $error("serial data moved off a link edge");

    c_conv_done: cover property ($rose(convert) && edge_cnt_reg == 5'h13);
    c_parked: cover property ((edge_cnt_reg == 5'h13 && !convert) [*8]);
    c_stalled: cover property (gap_cnt_reg > 10'(2 * FRAME));
endmodule : dsc_link_checker

/* testbench/dual_sar_adc_conversion_sequencer_bench.sv */
/* Bench joining the controller end and the converter end over the link.
   Assumes the controller makes convert and the link clock; the bench
   drives both resets, the analog words, run and word_ready. */
`timescale 1ns/1ns
module dual_sar_adc_conversion_sequencer_bench;
    import dsc_pkg::*;
    localparam int FRAME = 90; // Shortened frame keeps the run brief
    localparam int DLY = 2;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst, dev_rst, run, word_ready, word_valid, result_done, hold;
    logic [17:0] ain_a, ain_b, word_a, word_b, result_a, result_b, sa, sb;
    int failures = 0, checks = 0, cyc = 0, ecnt = 0, nconv = 0;
    logic [35:0] expq[$];

    dsc_link_if link();
    dsc_conv_host #(.FRAME(FRAME)) u_dsc_conv_host (.clock(clock),
        .rst(rst), .link(link), .run(run), .word_valid(word_valid),
        .word_ready(word_ready), .word_a(word_a), .word_b(word_b));
    dsc_conv_dev u_dsc_conv_dev (.link(link), .rst(dev_rst),
        .ain_a(ain_a), .ain_b(ain_b), .hold(hold), .result_a(result_a),
        .result_b(result_b), .result_done(result_done));
    dsc_link_checker #(.FRAME(FRAME)) u_dsc_link_checker (.clock(clock),
        .rst(rst), .link_rst(dev_rst), .convert(link.convert),
        .conversion_clock_input(link.conversion_clock_input),
        .data_a(link.data_a), .data_b(link.data_b));

    // ====================
    // Clock, watchdog and link monitors
    always #20 clock = ~clock;
    // Cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            stop_test();
        end
    end
    // Edge count restarts on every convert
    always @(posedge link.convert) begin
        ecnt = 0;
        nconv++;
    end
    always @(posedge link.conversion_clock_input) ecnt++;
    // Sample on the falling edge, well clear of the launching edge
    always @(negedge link.conversion_clock_input) begin
        if (ecnt >= 2 && ecnt <= 19) begin
            sa = {sa[16:0], link.data_a};
            sb = {sb[16:0], link.data_b};
        end
    end

    // ====================
    // Shared tasks
    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task stop_test;
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task step;
        @(posedge clock);
        #DLY;
    endtask : step

    // Watchdog bounds both waits
    task wait_valid;
        while (word_valid !== 1'b1) step();
    endtask : wait_valid

    task wait_conv;
        while (link.convert !== 1'b1) step();
    endtask : wait_conv

    task pop;
        word_ready = 1'b1;
        step();
        word_ready = 1'b0;
    endtask : pop

    // ====================
    // Scenarios
    // One conversion, judged at the wire, device and user sides
    task automatic one_conv(input logic [17:0] a, input logic [17:0] b);
        ain_a = a;
        ain_b = b;
        run = 1'b1;
        wait_conv();
        run = 1'b0;
        wait_valid();
        chk("word", {a, b}, {word_a, word_b});
        chk("serial", {a, b}, {sa, sb});
        chk("result", {a, b}, {result_a, result_b});
        chk("edges", 36'h0_0013, 36'(ecnt));
        chk("track", 36'h0_0001, {34'h0, hold, result_done});
        pop();
        chk("empty", 36'h0_0000, {35'h0, word_valid});
    endtask : one_conv

    // Fill the buffer until converts stall, then drain with pauses
    task automatic fill_drain;
        int k;
        logic [35:0] e;
        k = nconv;
        word_ready = 1'b0;
        ain_a = 18'h0_5A5A;
        ain_b = 18'h2_A5A5;
        run = 1'b1;
        repeat (16) begin
            wait_conv();
            expq.push_back({ain_a, ain_b});
            ain_a = ain_a + 18'h0_4321;
            ain_b = ain_b - 18'h0_1357;
            while (link.convert !== 1'b0) step();
        end
        repeat (3 * FRAME) step();
        chk("converts", 36'h0_0010, 36'(nconv - k));
        run = 1'b0;
        repeat (16) begin
            wait_valid();
            e = expq.pop_front();
            chk("queued", e, {word_a, word_b});
            pop();
            step();
            step();
        end
        chk("drained", 36'h0_0000, {35'h0, word_valid});
    endtask : fill_drain

    // ====================
    // Main sequence
    // Device reset needs link edges, so one frame runs under it
    initial begin
        rst = 1'b1;
        dev_rst = 1'b1;
        run = 1'b0;
        word_ready = 1'b0;
        ain_a = 18'h0_0000;
        ain_b = 18'h0_0000;
        repeat (3) @(posedge clock);
        #DLY;
        rst = 1'b0;
        run = 1'b1;
        wait_conv();
        run = 1'b0;
        wait_valid();
        pop();
        dev_rst = 1'b0;
        one_conv(18'h1_FFFF, 18'h2_0000);
        one_conv(18'h0_0000, 18'h3_FFFF);
        one_conv(18'h3_FFFF, 18'h0_0000);
        one_conv(18'h2_0000, 18'h1_FFFF);
        fill_drain();
        stop_test();
    end
endmodule : dual_sar_adc_conversion_sequencer_bench

/* verilog/dsc_conv_dev.sv */
/*
 * Converter end: captures both inputs on the convert edge and resolves
 * them bit by bit on conversion clock rising edges, shifting both
 * results out in lockstep.
 * Assumes the controller keeps the guard time between the convert edge
 * and the first clock edge, and that the clock runs while rst is high.
 * The analog inputs are modelled as two's complement words.
 */
`timescale 1ns/1ns

// Overview of operation
// - Convert rising edge starts a conversion
// - Both channels go to hold together
// - Convert low 50ns before edge nineteen
// - Convert pulse about 81ns at 192kHz
// - Only clock rising edges matter, any duty
// - Receiver captures data on clock falling edge
// - Exactly nineteen edges; extra edges ignored
// - Track from edge nineteen until next convert
// - Controller preferably stops clock after nineteen
// - MSB decided on first edge after convert
// - No clock edge inside guard interval
// - One bit per interval, MSB first
// - Serial bit one clock after decision
// - Result is an 18-bit word
// - Two's complement output coding
// - Sample rate 48k, 192k, 222kHz
// - Convert spacing has no upper limit
module dsc_conv_dev #(
    parameter int WIDTH = dsc_pkg::WORD_BITS
) (
    dsc_link_if.device link,
    input wire logic rst,
    input wire logic [WIDTH-1:0] ain_a,
    input wire logic [WIDTH-1:0] ain_b,
    output logic hold,
    output logic [WIDTH-1:0] result_a,
    output logic [WIDTH-1:0] result_b,
    output logic result_done
);
    import dsc_pkg::*;

    localparam logic [WIDTH-1:0] SIGN = WIDTH'(1) << (WIDTH - 1);

    // ========================================================
    // Comparator: keep the trial bit if the approximation stays
    // at or below the held input (offset binary)
    function automatic logic keep_bit(
        input logic [WIDTH-1:0] partial,
        input logic [WIDTH-1:0] level,
        input logic [STEP_BITS-1:0] idx
    );
        logic [WIDTH-1:0] trial;
        trial = partial | (WIDTH'(1) << idx);
        return trial <= level;
    endfunction : keep_bit

    // ========================================================
    // Convert edge domain
    // Initial values stand in for a reset: this domain has no
    // clock other than the strobe itself
    logic start_tgl = 1'b0;
    logic [WIDTH-1:0] held_reg [2] = '{default: '0};

    // Each convert edge is an event for the link side
    always_ff @(posedge link.convert) begin
        start_tgl <= ~start_tgl;
    end

    // Both inputs frozen on the same edge, so they are co-phased
    always_ff @(posedge link.convert) begin
        held_reg[0] <= ain_a;
        held_reg[1] <= ain_b;
    end

    // ========================================================
    // Link clock domain
    // The toggle and held words are read directly: the guard time
    // before the first clock edge is what lets them settle, which is
    // why an edge inside that interval corrupts the MSB.
    logic seen_reg;
    logic busy_reg;
    logic [STEP_BITS-1:0] step_reg;
    logic done_reg;
    logic new_conv;
    logic last_edge;
    logic [STEP_BITS-1:0] bit_idx;
    logic [WIDTH-1:0] word_out [2];
    logic ser_out [2];

    assign new_conv = start_tgl ^ seen_reg;
    assign last_edge = busy_reg && (step_reg == STEP_BITS'(EDGES - 1));
    assign bit_idx = new_conv ? STEP_BITS'(WIDTH - 1)
                              : STEP_BITS'(WIDTH - 1) - step_reg;

    // Acknowledge the convert event on the edge that acts on it
    always_ff @(posedge link.conversion_clock_input) begin
        if (rst) begin
            seen_reg <= start_tgl;
        end else if (new_conv) begin
            seen_reg <= start_tgl;
        end
    end

    // Edge counter: edge 1 opens, edge 19 closes; later edges do
    // nothing until the next convert, so a free-running clock is safe
    always_ff @(posedge link.conversion_clock_input) begin
        if (rst) begin
            busy_reg <= 1'b0;
            step_reg <= '0;
        end else if (new_conv) begin
            busy_reg <= 1'b1;
            step_reg <= STEP_BITS'(1);
        end else if (last_edge) begin
            busy_reg <= 1'b0;
            step_reg <= '0;
        end else if (busy_reg) begin
            step_reg <= step_reg + 1'b1;
        end
    end

    // Completion flag stands from edge 19 to the next first edge
    always_ff @(posedge link.conversion_clock_input) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else if (new_conv) begin
            done_reg <= 1'b0;
        end else if (last_edge) begin
            done_reg <= 1'b1;
        end
    end

    // ========================================================
    // One approximation rank per channel, both stepped together
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [WIDTH-1:0] sar_reg;
            logic [WIDTH-1:0] res_reg;
            logic dec_reg;
            logic out_reg;
            logic [WIDTH-1:0] level;
            logic keep;

            // Flip the sign so unsigned compare orders the codes
            assign level = held_reg[ch] ^ SIGN;
            assign keep = keep_bit(new_conv ? '0 : sar_reg, level,
                                   bit_idx);

            // Successive approximation, MSB first, one bit per edge
            always_ff @(posedge link.conversion_clock_input) begin
                if (rst) begin
                    sar_reg <= '0;
                end else if (new_conv) begin
                    sar_reg <= keep ? SIGN : '0;
                end else if (busy_reg && step_reg < STEP_BITS'(WIDTH)) begin
                    sar_reg[bit_idx] <= keep;
                end
            end

            // Latched decision, recoded to two's complement on the MSB
            always_ff @(posedge link.conversion_clock_input) begin
                if (rst) begin
                    dec_reg <= 1'b0;
                end else if (new_conv) begin
                    dec_reg <= ~keep;
                end else if (busy_reg && step_reg < STEP_BITS'(WIDTH)) begin
                    dec_reg <= keep;
                end
            end

            // Serial bit follows its decision by one clock, so the
            // last bit leaves on edge 19 and the line then holds
            always_ff @(posedge link.conversion_clock_input) begin
                if (rst) begin
                    out_reg <= 1'b0;
                end else if (busy_reg && !new_conv) begin
                    out_reg <= dec_reg;
                end
            end

            // Parallel copy of the finished word
            always_ff @(posedge link.conversion_clock_input) begin
                if (rst) begin
                    res_reg <= '0;
                end else if (last_edge) begin
                    res_reg <= sar_reg ^ SIGN;
                end
            end

            assign word_out[ch] = res_reg;
            assign ser_out[ch] = out_reg;
        end
    endgenerate

    // ========================================================
    // Outputs, all straight from flip-flops
    assign link.data_a = ser_out[0];
    assign link.data_b = ser_out[1];
    assign hold = busy_reg;
    assign result_a = word_out[0];
    assign result_b = word_out[1];
    assign result_done = done_reg;

endmodule : dsc_conv_dev

/* verilog/dsc_conv_host.sv */
/*
 * Controller end: issues convert strobes at the frame rate, makes the
 * conversion clock by dividing its own clock, gathers both serial
 * words and queues them in a FIFO for the user.
 * Assumes a 25 MHz clock; a full FIFO holds off the next convert.
 */
`timescale 1ns/1ns
module dsc_conv_host #(
    parameter int WIDTH = dsc_pkg::WORD_BITS,
    parameter int DEPTH = dsc_pkg::FIFO_DEPTH,
    parameter int FRAME = dsc_pkg::FRAME_CYC
) (
    input wire logic clock,
    input wire logic rst,
    dsc_link_if.host link,
    input wire logic run,
    output logic word_valid,
    input wire logic word_ready,
    output logic [WIDTH-1:0] word_a,
    output logic [WIDTH-1:0] word_b
);
    import dsc_pkg::*;

    dsc_state_t state_reg;
    logic [15:0] frame_reg;
    logic [7:0] div_reg;
    logic [STEP_BITS-1:0] edge_reg;
    logic conv_reg;
    logic clk_reg;
    logic [1:0] sync_a_reg;
    logic [1:0] sync_b_reg;
    logic [WIDTH-1:0] sh_a_reg;
    logic [WIDTH-1:0] sh_b_reg;
    logic fifo_ready;
    logic start_conv;
    logic div_wrap;
    logic rise;
    logic last_fall;
    logic fall_d_reg;
    logic take;
    logic push_word;

    assign start_conv = (state_reg == ST_IDLE) && run && fifo_ready;
    assign div_wrap = (state_reg == ST_CLOCKS)
                      && (div_reg == 8'(CLK_HALF_CYC - 1));
    assign rise = div_wrap && !clk_reg;
    assign last_fall = div_wrap && clk_reg
                       && (edge_reg == STEP_BITS'(EDGES));
    // Edge 1 launches no data, so bits come from edges 2 to 19
    assign take = fall_d_reg && (edge_reg > STEP_BITS'(1));
    assign push_word = fall_d_reg && (edge_reg == STEP_BITS'(EDGES));

    // ========================================================
    // Frame sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_conv) begin
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (frame_reg == 16'(CONV_HIGH_CYC - 1)) begin
                        state_reg <= ST_GUARD;
                    end
                end
                ST_GUARD: begin
                    if (frame_reg == 16'(GUARD_CYC - 1)) begin
                        state_reg <= ST_CLOCKS;
                    end
                end
                ST_CLOCKS: begin
                    if (last_fall) begin
                        state_reg <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // Spacing may be stretched without limit by run
                    if (frame_reg >= 16'(FRAME - 1)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Cycles since the convert edge
    always_ff @(posedge clock) begin
        if (rst || start_conv) begin
            frame_reg <= '0;
        end else if (state_reg != ST_IDLE) begin
            frame_reg <= frame_reg + 1'b1;
        end
    end

    // Convert strobe, dropped long before edge 19
    always_ff @(posedge clock) begin
        if (rst) begin
            conv_reg <= 1'b0;
        end else if (start_conv) begin
            conv_reg <= 1'b1;
        end else if (state_reg == ST_CONV
                     && frame_reg == 16'(CONV_HIGH_CYC - 1)) begin
            conv_reg <= 1'b0;
        end
    end

    // ========================================================
    // Clock divider: runs only for the 19 edges, then parks low
    always_ff @(posedge clock) begin
        if (rst) begin
            div_reg <= '0;
        end else if (state_reg == ST_GUARD) begin
            div_reg <= 8'(CLK_HALF_CYC - 1);
        end else if (div_wrap) begin
            div_reg <= '0;
        end else if (state_reg == ST_CLOCKS) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clk_reg <= 1'b0;
        end else if (div_wrap) begin
            clk_reg <= ~clk_reg;
        end
    end

    // Rising edges issued this frame
    always_ff @(posedge clock) begin
        if (rst || start_conv) begin
            edge_reg <= '0;
        end else if (rise) begin
            edge_reg <= edge_reg + 1'b1;
        end
    end

    // ========================================================
    // Data capture: pins pass two flops, so a bit launched on a link
    // rise is only settled at the sync output two cycles later,
    // which is the cycle after the following fall
    always_ff @(posedge clock) begin
        if (rst) begin
            fall_d_reg <= 1'b0;
        end else begin
            fall_d_reg <= div_wrap && clk_reg;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_a_reg <= '0;
            sync_b_reg <= '0;
        end else begin
            sync_a_reg <= {sync_a_reg[0], link.data_a};
            sync_b_reg <= {sync_b_reg[0], link.data_b};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sh_a_reg <= '0;
            sh_b_reg <= '0;
        end else if (take) begin
            sh_a_reg <= {sh_a_reg[WIDTH-2:0], sync_a_reg[1]};
            sh_b_reg <= {sh_b_reg[WIDTH-2:0], sync_b_reg[1]};
        end
    end

    assign link.convert = conv_reg;
    assign link.conversion_clock_input = clk_reg;

    // ========================================================
    // Result queue; room is checked before each convert. The last bit
    // joins the word on the way in, as it is shifted on the same edge
    dsc_fifo #(
        .WIDTH(2 * WIDTH),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(push_word),
        .in_ready(fifo_ready),
        .in_data({sh_a_reg[WIDTH-2:0], sync_a_reg[1],
                  sh_b_reg[WIDTH-2:0], sync_b_reg[1]}),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data({word_a, word_b})
    );
endmodule : dsc_conv_host

/* verilog/dsc_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; full and empty come from an occupancy count.
 */
`timescale 1ns/1ns
module dsc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import dsc_pkg::*;

    localparam int PB = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CB = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PB-1:0] wr_reg;
    logic [PB-1:0] rd_reg;
    logic [CB-1:0] count_reg;
    logic push;
    logic pop;

    // ========================================================
    // Handshakes
    assign in_ready = (count_reg != CB'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == PB'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == PB'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule : dsc_fifo

/* verilog/dsc_link_if.sv */
/*
 * Link between converter and controller: convert strobe, conversion
 * clock and two serial data lines.
 * Assumes the controller makes both the strobe and the clock.
 */
`timescale 1ns/1ns
interface dsc_link_if;
    logic convert;
    logic conversion_clock_input;
    logic data_a;
    logic data_b;

    modport device (
        input convert,
        input conversion_clock_input,
        output data_a,
        output data_b
    );

    modport host (
        output convert,
        output conversion_clock_input,
        input data_a,
        input data_b
    );
endinterface : dsc_link_if

/* verilog/dsc_pkg.sv */
/*
 * Shared constants for the dual converter sequencer: word layout,
 * conversion length and host-side timing.
 * Assumes a 25 MHz host clock; the convert, guard and frame counts are derived from that period.
 */
package dsc_pkg;

    // ========================================================
    // Word layout
    localparam int WORD_BITS = 18;
    localparam int CODE_COUNT = 262144;
    localparam logic [17:0] CODE_SIGN_MASK = 18'h2_0000;
    localparam logic [17:0] CODE_POS_FULL = 18'h1_FFFF;
    localparam logic [17:0] CODE_ZERO = 18'h0_0000;
    localparam logic [17:0] CODE_NEG_STEP = 18'h3_FFFF;
    localparam logic [17:0] CODE_NEG_FULL = 18'h2_0000;

    // ========================================================
    // Conversion length in link clock rising edges
    localparam int EDGES = 19;
    localparam int STEP_BITS = 5;

    // ========================================================
    // Host timing, times in ns and derived host clock counts
    localparam int CLOCK_NS = 40;
    localparam int CONV_HIGH_NS = 81;
    localparam int CONV_HIGH_CYC = (CONV_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int FALL_MARGIN_NS = 50;
    localparam int GUARD_NS = 200;
    localparam int GUARD_CYC = (GUARD_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int SAMPLE_RATE_HZ = 192000;
    localparam int FRAME_NS = 1000000000 / SAMPLE_RATE_HZ;
    localparam int FRAME_CYC = FRAME_NS / CLOCK_NS;
    localparam int CLK_HALF_CYC = 2;
    localparam int FIFO_DEPTH = 16;

    // Host sequencer states, one bit flipping per step from ST_IDLE to ST_GAP
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CONV = 3'b001,
        ST_GUARD = 3'b011,
        ST_CLOCKS = 3'b010,
        ST_GAP = 3'b110
    } dsc_state_t;

endpackage : dsc_pkg
